// >>> include/ptzr_regs.vh
// Register map, field positions and timing constants of the origin-return sequencer.
// Included by every design file; definitions only.
`ifndef PTZR_REGS_VH
`define PTZR_REGS_VH
// Per-channel block: byte offset inside a 32-byte channel window
`define PTZR_OFF_CMD      5'h00
`define PTZR_OFF_CFG      5'h04
`define PTZR_OFF_HSPD     5'h08
`define PTZR_OFF_CSPD     5'h0c
`define PTZR_OFF_MAXSPD   5'h10
`define PTZR_OFF_ROUTE    5'h14
`define PTZR_OFF_POS      5'h18
`define PTZR_OFF_CHSTAT   5'h1c
// Global registers: byte address
`define PTZR_ADR_IRQSTAT  8'h80
`define PTZR_ADR_IRQMASK  8'h84
`define PTZR_ADR_SCAN     8'h88
`define PTZR_ADR_FLAGS    8'h8c
// Command bits
`define PTZR_CMD_START    0
`define PTZR_CMD_ABORT    1
// Configuration bits
`define PTZR_CFG_WIDE     0
`define PTZR_CFG_ADAPTER  1
`define PTZR_CFG_CLREN    2
`define PTZR_CFG_ROUTEEN  3
`define PTZR_CFG_FWDLIM   4
`define PTZR_CFG_REVLIM   5
`define PTZR_CFG_SEL_LSB  8
`define PTZR_CFG_SEL_MSB  11
// Interrupt status fields
`define PTZR_IRQ_DONE     0
`define PTZR_IRQ_ABN      4
`define PTZR_IRQ_REFUSE   8
// Speed limits in Hz
`define PTZR_MIN_HZ       32'h0000000a
`define PTZR_MAX16_HZ     32'h00007fff
`define PTZR_MAXMAIN_HZ   32'h000186a0
`define PTZR_MAXADP_HZ    32'h00030d40
`define PTZR_MAXSPD_RST   32'h000186a0
`define PTZR_DECEL_STEP   18'h003e8
// Clock and times
`define PTZR_CLK_HZ       26'h17d7840
`define PTZR_CLK_NS       32'h00000028
`define PTZR_MS_NS        32'h000f4240
`define PTZR_MS_CYCLES    (`PTZR_MS_NS / `PTZR_CLK_NS)
`define PTZR_FILTER_MS    4'ha
`define PTZR_CLEAR_MS     16'h0014
`define PTZR_CLR_BASE     4'h4
`endif

// >>> src/ptzr_channel.v
// One pulse-output channel: origin-return sequence, pulse generator, position counter.
// Assumes a one-cycle millisecond tick and a near-point level already filtered as needed.
`include "ptzr_regs.vh"

module ptzr_channel (
  input  wire        clk,
  input  wire        reset,
  input  wire        msTick,
  input  wire        start,
  input  wire        abort,
  input  wire [17:0] homeFreq,
  input  wire [17:0] creepFreq,
  input  wire        nearPoint,
  input  wire        limitHit,
  input  wire        clearEn,
  input  wire [15:0] clearMs,
  input  wire        posLoad,
  input  wire [31:0] posData,
  output reg         pulseOut,
  output wire        busy,
  output reg         clearActive,
  output reg  [31:0] position,
  output reg         donePulse,
  output reg         abnPulse
);
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_HOME  = 6'h02;
  localparam [5:0] ST_CREEP = 6'h04;
  localparam [5:0] ST_DECEL = 6'h08;
  localparam [5:0] ST_STOP  = 6'h10;
  localparam [5:0] ST_CLEAR = 6'h20;

  reg  [5:0]  state_reg;
  reg  [17:0] freq_reg;
  reg  [25:0] acc_reg;
  reg         near_reg;
  reg         abn_reg;
  reg         quiet_reg;
  reg  [15:0] clrCnt_reg;
  wire [26:0] accSum;
  wire        wrap;
  wire        running;

  // Phase accumulator: two wraps per pulse period
  assign accSum  = {1'b0, acc_reg} + {8'h00, freq_reg, 1'b0};
  assign wrap    = accSum >= {1'b0, `PTZR_CLK_HZ};
  assign running = (state_reg == ST_HOME) | (state_reg == ST_CREEP) | (state_reg == ST_DECEL);
  assign busy    = state_reg != ST_IDLE;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= ST_IDLE;
      freq_reg    <= 18'h00000;
      acc_reg     <= 26'h0000000;
      near_reg    <= 1'b0;
      abn_reg     <= 1'b0;
      quiet_reg   <= 1'b0;
      clrCnt_reg  <= 16'h0000;
      pulseOut    <= 1'b0;
      clearActive <= 1'b0;
      position    <= 32'h00000000;
      donePulse   <= 1'b0;
      abnPulse    <= 1'b0;
    end else begin
      near_reg  <= nearPoint;
      donePulse <= 1'b0;
      abnPulse  <= 1'b0;
      if (running) begin
        if (wrap) begin
          acc_reg  <= accSum[25:0] - `PTZR_CLK_HZ;
          pulseOut <= ~pulseOut;
          if (!pulseOut)
            position <= position - 32'h00000001;
        end else begin
          acc_reg <= accSum[25:0];
        end
      end else if (posLoad) begin
        position <= posData;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            freq_reg  <= homeFreq;
            acc_reg   <= 26'h0000000;
            abn_reg   <= 1'b0;
            quiet_reg <= 1'b0;
            state_reg <= ST_HOME;
          end
        end
        ST_HOME: begin
          if (limitHit | abort) begin
            abn_reg   <= limitHit;
            quiet_reg <= abort & ~limitHit;
            state_reg <= ST_DECEL;
          end else if (nearPoint & ~near_reg) begin
            freq_reg  <= creepFreq;
            state_reg <= ST_CREEP;
          end
        end
        ST_CREEP: begin
          if (limitHit | abort) begin
            abn_reg   <= limitHit;
            quiet_reg <= abort & ~limitHit;
            state_reg <= ST_DECEL;
          end else if (~nearPoint & near_reg) begin
            state_reg <= ST_STOP;
          end
        end
        ST_DECEL: begin
          if (msTick) begin
            if (freq_reg <= `PTZR_DECEL_STEP)
              state_reg <= ST_STOP;
            else
              freq_reg <= freq_reg - `PTZR_DECEL_STEP;
          end
        end
        ST_STOP: begin
          pulseOut <= 1'b0;
          acc_reg  <= 26'h0000000;
          if (quiet_reg) begin
            state_reg <= ST_IDLE;
          end else if (abn_reg) begin
            abnPulse  <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            position  <= 32'h00000000;
            donePulse <= 1'b1;
            if (clearEn) begin
              clearActive <= 1'b1;
              clrCnt_reg  <= clearMs;
              state_reg   <= ST_CLEAR;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_CLEAR: begin
          if (msTick) begin
            if (clrCnt_reg == 16'h0000) begin
              clearActive <= 1'b0;
              state_reg   <= ST_IDLE;
            end else begin
              clrCnt_reg <= clrCnt_reg - 16'h0001;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // ptzr_channel

// >>> src/ptzr_top.v
// Origin-return sequencer for four pulse-train channels, with APB registers.
// Assumes synchronous inputs on clk; APB master follows the usual setup/access phases.
//
// Notes on behaviour
// - Homing speed clamped to maximum speed
// - Homing speed ranges by width and output
// - Stored homing speed registers are ignored
// - Creep speed range is 10 to 32767
// - Near-point rise slows to creep speed
// - Near-point fall stops pulses and finishes
// - Fast inputs act on edges directly
// - Slow inputs pass a 10 ms filter
// - Four channels, each with own registers
// - Reverse direction, position counts down
// - Clear pulse after near-point stop when enabled
// - Default clear outputs are points four-seven
// - Route enable sends clear to chosen point
// - Clear within 1 ms, 20 ms plus scan
// - Zero position, then complete flag
// - Limit decelerates, stops, flags abnormal end
`include "ptzr_regs.vh"

module ptzr_top #(
  parameter MS_CYCLES = `PTZR_MS_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [7:0]  fastIn,
  input  wire [7:0]  slowIn,
  output wire [3:0]  pulseOut,
  output reg  [15:0] outPoint,
  output reg         execCompleteFlag,
  output reg         execAbnormalFlag,
  output reg         irq
);
  reg  [31:0] cfg_reg    [0:3];
  reg  [31:0] hspd_reg   [0:3];
  reg  [15:0] cspd_reg   [0:3];
  reg  [31:0] maxspd_reg [0:3];
  reg  [15:0] route_reg  [0:3];
  reg  [11:0] irqStat_reg;
  reg  [11:0] irqMask_reg;
  reg  [15:0] scan_reg;
  reg  [31:0] msCnt_reg;
  reg         msTick;
  wire [7:0]  slowFilt;
  reg  [15:0] outNext;
  reg  [31:0] rdNext;
  reg  [11:0] irqNext;
  reg  [11:0] irqSet;
  reg         mapped;
  reg  [3:0]  dest;
  wire        setup;
  wire        access;
  wire        wrEn;
  wire        global;
  wire [1:0]  chSel;
  wire [4:0]  chOff;
  wire [3:0]  busy;
  wire [3:0]  clearActive;
  wire [3:0]  donePulse;
  wire [3:0]  abnPulse;
  wire [31:0] position   [0:3];
  wire [3:0]  startCh;
  wire [3:0]  abortCh;
  wire [3:0]  refused;
  wire [3:0]  posLoad;
  wire [15:0] clearMs;
  integer     c;
  integer     k;

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wrEn    = access & pwrite;
  assign global  = paddr[7];
  assign chSel   = paddr[6:5];
  assign chOff   = paddr[4:0];
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  // 20 ms plus one scan time
  assign clearMs = `PTZR_CLEAR_MS + scan_reg;

  // Homing speed: width and output type set the range, then the maximum speed caps it
  function [17:0] homeClamp;
    input [31:0] spd;
    input        wide;
    input        adapter;
    input [31:0] maxSpd;
    reg   [31:0] lim;
    reg   [31:0] v;
    begin
      lim = wide ? (adapter ? `PTZR_MAXADP_HZ : `PTZR_MAXMAIN_HZ) : `PTZR_MAX16_HZ;
      v   = wide ? spd : {16'h0000, spd[15:0]};
      if (maxSpd < lim)
        lim = maxSpd;
      if (v > lim)
        v = lim;
      if (v < `PTZR_MIN_HZ)
        v = `PTZR_MIN_HZ;
      homeClamp = v[17:0];
    end
  endfunction

  function [17:0] creepClamp;
    input [15:0] spd;
    reg   [31:0] v;
    begin
      v = {16'h0000, spd};
      if (v > `PTZR_MAX16_HZ)
        v = `PTZR_MAX16_HZ;
      if (v < `PTZR_MIN_HZ)
        v = `PTZR_MIN_HZ;
      creepClamp = v[17:0];
    end
  endfunction

  // Millisecond tick for filters and clear timing
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      msCnt_reg <= 32'h00000000;
      msTick    <= 1'b0;
    end else if (msCnt_reg == MS_CYCLES - 1) begin
      msCnt_reg <= 32'h00000000;
      msTick    <= 1'b1;
    end else begin
      msCnt_reg <= msCnt_reg + 32'h00000001;
      msTick    <= 1'b0;
    end
  end

  // slow inputs must hold a new level for the filter time
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gFilt
      reg [3:0] filtCnt_reg;
      reg       filt_reg;
      assign slowFilt[g] = filt_reg;
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          filtCnt_reg <= 4'h0;
          filt_reg    <= 1'b0;
        end else if (slowIn[g] == filt_reg) begin
          filtCnt_reg <= 4'h0;
        end else if (msTick) begin
          if (filtCnt_reg == `PTZR_FILTER_MS - 4'h1) begin
            filtCnt_reg <= 4'h0;
            filt_reg    <= slowIn[g];
          end else begin
            filtCnt_reg <= filtCnt_reg + 4'h1;
          end
        end
      end
    end
  endgenerate

  generate
    for (g = 0; g < 4; g = g + 1) begin : gCh
      wire [3:0] sel;
      wire       nearPoint;
      wire       limitHit;
      assign sel = cfg_reg[g][`PTZR_CFG_SEL_MSB:`PTZR_CFG_SEL_LSB];
      assign nearPoint = sel[3] ? slowFilt[sel[2:0]] : fastIn[sel[2:0]];
      assign limitHit  = cfg_reg[g][`PTZR_CFG_FWDLIM] | cfg_reg[g][`PTZR_CFG_REVLIM];
      assign startCh[g] = wrEn & ~global & (chSel == g) & (chOff == `PTZR_OFF_CMD)
                          & pwdata[`PTZR_CMD_START] & ~busy[g];
      // start on a busy channel is refused
      assign refused[g] = wrEn & ~global & (chSel == g) & (chOff == `PTZR_OFF_CMD)
                          & pwdata[`PTZR_CMD_START] & busy[g];
      assign abortCh[g] = wrEn & ~global & (chSel == g) & (chOff == `PTZR_OFF_CMD)
                          & pwdata[`PTZR_CMD_ABORT];
      assign posLoad[g] = wrEn & ~global & (chSel == g) & (chOff == `PTZR_OFF_POS);
      // homing speed only from the operand register
      ptzr_channel uChan (
        .clk         (clk),
        .reset       (reset),
        .msTick      (msTick),
        .start       (startCh[g]),
        .abort       (abortCh[g]),
        .homeFreq    (homeClamp(hspd_reg[g], cfg_reg[g][`PTZR_CFG_WIDE],
                                cfg_reg[g][`PTZR_CFG_ADAPTER], maxspd_reg[g])),
        .creepFreq   (creepClamp(cspd_reg[g])),
        .nearPoint   (nearPoint),
        .limitHit    (limitHit),
        .clearEn     (cfg_reg[g][`PTZR_CFG_CLREN]),
        .clearMs     (clearMs),
        .posLoad     (posLoad[g]),
        .posData     (pwdata),
        .pulseOut    (pulseOut[g]),
        .busy        (busy[g]),
        .clearActive (clearActive[g]),
        .position    (position[g]),
        .donePulse   (donePulse[g]),
        .abnPulse    (abnPulse[g])
      );
    end
  endgenerate

  // Clear output routing to output points
  always @* begin
    outNext = 16'h0000;
    dest    = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (cfg_reg[k][`PTZR_CFG_ROUTEEN])
        dest = route_reg[k][3:0];
      else
        dest = `PTZR_CLR_BASE + k[3:0];
      if (clearActive[k])
        outNext[dest] = 1'b1;
    end
  end

  // Address decode and read data, sampled in the setup phase
  always @* begin
    mapped = 1'b1;
    rdNext = 32'h00000000;
    if (global) begin
      case (paddr)
        `PTZR_ADR_IRQSTAT: rdNext = {20'h00000, irqStat_reg};
        `PTZR_ADR_IRQMASK: rdNext = {20'h00000, irqMask_reg};
        `PTZR_ADR_SCAN:    rdNext = {16'h0000, scan_reg};
        `PTZR_ADR_FLAGS:   rdNext = {30'h00000000, execAbnormalFlag, execCompleteFlag};
        default:           mapped = 1'b0;
      endcase
    end else begin
      case (chOff)
        `PTZR_OFF_CMD:    rdNext = 32'h00000000;
        `PTZR_OFF_CFG:    rdNext = cfg_reg[chSel];
        `PTZR_OFF_HSPD:   rdNext = hspd_reg[chSel];
        `PTZR_OFF_CSPD:   rdNext = {16'h0000, cspd_reg[chSel]};
        `PTZR_OFF_MAXSPD: rdNext = maxspd_reg[chSel];
        `PTZR_OFF_ROUTE:  rdNext = {16'h0000, route_reg[chSel]};
        `PTZR_OFF_POS:    rdNext = position[chSel];
        `PTZR_OFF_CHSTAT: rdNext = {30'h00000000, clearActive[chSel], busy[chSel]};
        default:          mapped = 1'b0;
      endcase
    end
  end

  // Sticky events: a read clears only what it reported, so an event at the setup edge survives
  always @* begin
    irqSet  = {refused, abnPulse, donePulse};
    irqNext = irqStat_reg;
    if (access & ~pwrite & (paddr == `PTZR_ADR_IRQSTAT))
      irqNext = irqStat_reg & ~prdata[11:0];
    irqNext = irqNext | irqSet;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (c = 0; c < 4; c = c + 1) begin
        cfg_reg[c]    <= 32'h00000000;
        hspd_reg[c]   <= 32'h00000000;
        cspd_reg[c]   <= 16'h0000;
        maxspd_reg[c] <= `PTZR_MAXSPD_RST;
        route_reg[c]  <= 16'h0000;
      end
      irqStat_reg      <= 12'h000;
      irqMask_reg      <= 12'h000;
      scan_reg         <= 16'h0000;
      prdata           <= 32'h00000000;
      outPoint         <= 16'h0000;
      execCompleteFlag <= 1'b0;
      execAbnormalFlag <= 1'b0;
      irq              <= 1'b0;
    end else begin
      irqStat_reg <= irqNext;
      irq         <= |(irqNext & irqMask_reg);
      outPoint    <= outNext;
      if (setup & ~pwrite)
        prdata <= rdNext;
      // complete flag, abnormal flag; a new start clears both
      if (|donePulse)
        execCompleteFlag <= 1'b1;
      else if (|startCh)
        execCompleteFlag <= 1'b0;
      if (|abnPulse)
        execAbnormalFlag <= 1'b1;
      else if (|startCh)
        execAbnormalFlag <= 1'b0;
      if (wrEn & mapped) begin
        if (global) begin
          if (paddr == `PTZR_ADR_IRQMASK)
            irqMask_reg <= pwdata[11:0];
          if (paddr == `PTZR_ADR_SCAN)
            scan_reg <= pwdata[15:0];
        end else begin
          case (chOff)
            `PTZR_OFF_CFG:    cfg_reg[chSel]    <= pwdata;
            `PTZR_OFF_HSPD:   hspd_reg[chSel]   <= pwdata;
            `PTZR_OFF_CSPD:   cspd_reg[chSel]   <= pwdata[15:0];
            `PTZR_OFF_MAXSPD: maxspd_reg[chSel] <= pwdata;
            `PTZR_OFF_ROUTE:  route_reg[chSel]  <= pwdata[15:0];
            default:          ;
          endcase
        end
      end
    end
  end
endmodule // ptzr_top

// >>> tb/ptzr_checker_assertions.sv
// Concurrent checks on the ports of the origin-return sequencer.
// Bound to ptzr_top; one clock domain, async active-high reset.
module ptzr_checker #(
  parameter MS_CYCLES = 25000
) (
  input wire        clk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  fastIn,
  input wire [7:0]  slowIn,
  input wire [3:0]  pulseOut,
  input wire [15:0] outPoint,
  input wire        execCompleteFlag,
  input wire        execAbnormalFlag,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [15:0] scanMs;
  reg  [11:0] maskReg;
  reg  [31:0] holdCnt;
  wire        acc = psel && penable;
  // Shadows of scan time and mask, and how long a clear pulse has stood
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scanMs <= 16'h0000;
      maskReg <= 12'h000;
      holdCnt <= 32'h0;
    end else begin
      if (acc && pready && pwrite && paddr == 8'h88)
        scanMs <= pwdata[15:0];
      if (acc && pready && pwrite && paddr == 8'h84)
        maskReg <= pwdata[11:0];
      holdCnt <= (|outPoint) ? holdCnt + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ready_zero_wait_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  slverr_unmapped_a: assert property (acc && paddr >= 8'h90 |-> pslverr)
    else $error("unmapped access not flagged");
  slverr_mapped_a: assert property (
    acc && paddr < 8'h90 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged as error");
  slverr_idle_a: assert property (!acc |-> !pslverr)
    else $error("error response outside access");
  unmapped_zero_a: assert property (acc && !pwrite && paddr >= 8'h90 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  clear_min_a: assert property (
    $fell(|outPoint) |-> holdCnt >= (20 + scanMs) * MS_CYCLES - 1)
    else $error("clear pulse too short");
  clear_max_a: assert property (
    (|outPoint) |-> holdCnt < (21 + scanMs) * MS_CYCLES + 2)
    else $error("clear pulse too long");
  clear_after_done_a: assert property ($rose(|outPoint) |-> execCompleteFlag)
    else $error("clear pulse without completion");
  irq_done_a: assert property (
    $rose(execCompleteFlag) && maskReg[3:0] == 4'hf |-> ##[0:2] irq)
    else $error("completion did not raise interrupt");
  irq_abn_a: assert property (
    $rose(execAbnormalFlag) && maskReg[7:4] == 4'hf |-> ##[0:2] irq)
    else $error("abnormal end did not raise interrupt");
endmodule // ptzr_checker

// >>> tb/ptzr_drive_model.sv
// Drive and near-point sensor: counts pulses of one channel, times them,
// and raises the normally-open near-point contact between two pulse counts.
module ptzr_drive_model (
  input  wire        clk,
  input  wire        reset,
  input  wire [3:0]  pulseOut,
  input  wire [1:0]  watchCh,
  input  wire        useSlow,
  input  wire [15:0] nearOnAt,
  input  wire [15:0] nearOffAt,
  input  wire        arm,
  output wire [7:0]  fastIn,
  output wire [7:0]  slowIn,
  output reg  [15:0] pulseCnt,
  output reg  [31:0] period,
  output reg  [31:0] cyc,
  output reg  [31:0] fellAt
);
  timeunit 1ns;
  timeprecision 1ns;
  reg        near;
  reg        prevPulse;
  reg [31:0] lastRise;
  wire       rise = pulseOut[watchCh] && !prevPulse;
  // Open contact reads low; only the watched channel's input moves
  assign fastIn = useSlow ? 8'h00 : {7'h00, near} << watchCh;
  assign slowIn = useSlow ? {7'h00, near} << watchCh : 8'h00;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {near, prevPulse, pulseCnt, period, cyc, fellAt, lastRise} <= 'h0;
    end else begin
      cyc <= cyc + 32'h1;
      prevPulse <= pulseOut[watchCh];
      if (arm) begin
        pulseCnt <= 16'h0;
        near <= 1'b0;
        lastRise <= cyc;
      end else if (rise) begin
        pulseCnt <= pulseCnt + 16'h1;
        period <= cyc - lastRise;
        lastRise <= cyc;
        if (pulseCnt + 16'h1 == nearOnAt)
          near <= 1'b1;
        if (pulseCnt + 16'h1 == nearOffAt) begin
          near <= 1'b0;
          fellAt <= cyc;
        end
      end
    end
  end
endmodule // ptzr_drive_model

// >>> tb/pulse_train_zero_return_tb.sv
// Self-checking bench for the origin-return sequencer with a drive model.
// Millisecond scaled to 10 clocks; APB master at zero wait states or more.
module pulse_train_zero_return_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam MS_CYCLES = 10;
  reg         clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  reg  [7:0]  paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg         err, slow = 0, arm = 0;
  reg  [1:0]  wCh = 0;
  reg  [15:0] onAt = 0, offAt = 0;
  wire [31:0] prdata, per, cyc, fell;
  wire        pready, pslverr, execCompleteFlag, execAbnormalFlag, irq;
  wire [7:0]  fastIn, slowIn;
  wire [3:0]  pulseOut;
  wire [15:0] outPoint, pCnt;
  int         errCount = 0, checkCount = 0, n;
  always #20 clk = ~clk;
  ptzr_top #(.MS_CYCLES(MS_CYCLES)) i_ptzr_top (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fastIn(fastIn), .slowIn(slowIn),
    .pulseOut(pulseOut), .outPoint(outPoint), .execCompleteFlag(execCompleteFlag),
    .execAbnormalFlag(execAbnormalFlag), .irq(irq));
  ptzr_drive_model i_ptzr_drive_model (.clk(clk), .reset(reset), .pulseOut(pulseOut),
    .watchCh(wCh), .useSlow(slow), .nearOnAt(onAt), .nearOffAt(offAt), .arm(arm),
    .fastIn(fastIn), .slowIn(slowIn), .pulseCnt(pCnt), .period(per), .cyc(cyc),
    .fellAt(fell));
  task endOfTest;
    if (errCount == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [32:0] got, input [32:0] lo, input [32:0] hi);
    checkCount++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task xfer(input [7:0] a, input w, input [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task waitCnt(input [15:0] k);
    for (n = 0; n < 20000 && pCnt < k; n++) @(posedge clk);
  endtask
  task startRun(input [1:0] ch, input s, input [15:0] on, input [15:0] off, input [7:0] a);
    @(posedge clk);
    wCh <= ch;
    slow <= s;
    onAt <= on;
    offAt <= off;
    arm <= 1;
    @(posedge clk);
    arm <= 0;
    xfer(a, 1, 32'h1);
    repeat (2) @(posedge clk);
    chk(execCompleteFlag, 0, 0);
  endtask
  task clearWidth(input [15:0] pat, input [15:0] scanMs);
    for (n = 0; n < 30 && outPoint == 0; n++) @(posedge clk);
    chk(outPoint, pat, pat);
    for (n = 0; n < 400 && outPoint != 0; n++) @(posedge clk);
    chk(n, (20 + scanMs) * MS_CYCLES - 1, (21 + scanMs) * MS_CYCLES + 2);
  endtask
  task tReset;
    xfer(8'h50, 0, 0);
    chk(rd, 32'h186a0, 32'h186a0);
    xfer(8'h90, 0, 0);
    chk({err, rd}, 33'h100000000, 33'h100000000);
    xfer(8'h48, 1, 32'h1234);
    xfer(8'h48, 0, 0);
    chk(rd, 32'h1234, 32'h1234);
    xfer(8'h84, 1, 32'hfff);
  endtask
  task tFast;
    xfer(8'h04, 1, 32'h7);
    xfer(8'h08, 1, 32'h30d40);
    xfer(8'h10, 1, 32'hc350);
    xfer(8'h0c, 1, 32'h61a8);
    xfer(8'h18, 1, 32'h64);
    startRun(0, 0, 3, 5, 8'h00);
    xfer(8'h1c, 0, 0);
    chk(rd[0], 1, 1);
    xfer(8'h00, 1, 32'h1);
    xfer(8'h80, 0, 0);
    chk(rd[8], 1, 1);
    waitCnt(2);
    xfer(8'h18, 0, 0);
    chk(rd, 97, 98);
    waitCnt(3);
    chk(per, 498, 502);
    waitCnt(5);
    chk(per, 998, 1002);
    for (n = 0; n < 50 && execCompleteFlag !== 1'b1; n++) @(posedge clk);
    chk(cyc - fell, 1, 5);
    clearWidth(16'h0010, 16'h0000);
    chk(irq, 1, 1);
    xfer(8'h18, 0, 0);
    chk(rd, 0, 0);
    xfer(8'h80, 0, 0);
    chk(rd[0], 1, 1);
    xfer(8'h1c, 0, 0);
    chk(rd[0], 0, 0);
  endtask
  task tSlow;
    xfer(8'h24, 1, 32'h90c);
    xfer(8'h28, 1, 32'h4e20);
    xfer(8'h2c, 1, 32'h2710);
    xfer(8'h34, 1, 32'h9);
    xfer(8'h88, 1, 32'h2);
    startRun(1, 1, 2, 3, 8'h20);
    for (n = 0; n < 20000 && execCompleteFlag !== 1'b1; n++) @(posedge clk);
    chk(cyc - fell, 9 * MS_CYCLES + 4, 10 * MS_CYCLES + 5);
    clearWidth(16'h0200, 16'h0002);
  endtask
  task tLimit;
    xfer(8'h80, 0, 0);
    xfer(8'h64, 1, 32'h0);
    xfer(8'h68, 1, 32'h18000);
    xfer(8'h78, 1, 32'h3e8);
    startRun(3, 0, 0, 0, 8'h60);
    chk(irq, 0, 0);
    waitCnt(2);
    chk(per, 760, 765);
    xfer(8'h64, 1, 32'h20);
    for (n = 0; n < 800 && execAbnormalFlag !== 1'b1; n++) @(posedge clk);
    chk({execAbnormalFlag, execCompleteFlag, outPoint}, 18'h20000, 18'h20000);
    repeat (3) @(posedge clk);
    chk(irq, 1, 1);
    xfer(8'h78, 0, 0);
    chk(rd, 32'h3c0, 32'h3e6);
    xfer(8'h80, 0, 0);
    chk(rd[7], 1, 1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    tReset;
    tFast;
    tSlow;
    tLimit;
    endOfTest;
  end
  initial begin
    #2000000;
    errCount++;
    endOfTest;
  end
endmodule // pulse_train_zero_return_tb
bind ptzr_top ptzr_checker #(.MS_CYCLES(MS_CYCLES)) i_ptzr_checker (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .fastIn(fastIn), .slowIn(slowIn),
  .pulseOut(pulseOut), .outPoint(outPoint), .execCompleteFlag(execCompleteFlag),
  .execAbnormalFlag(execAbnormalFlag), .irq(irq));
